//--- iprt_pkg.sv
// Shared constants, source table and types of the interrupt packet router
package iprt_pkg;
    // Source population
    localparam int SLOT_LINES = 16;        // Four slots, four lines each
    localparam int OBIO_LINES = 12;        // Onboard I/O level sources
    localparam int ERR_LINES = 3;          // Internal error level sources
    localparam int GFX_LINES = 1;          // Pulse-type graphics source
    localparam int SRC_COUNT = 32;         // Sum of the groups above
    localparam int IDX_W = 5;              // Source index width
    localparam int CODE_W = 6;             // Interrupt code width
    localparam int PRI_W = 4;              // Priority width

    // Codes and packet framing
    localparam logic [CODE_W-1:0] NO_INT_CODE = 6'h3f;   // Reserved idle code
    localparam int PKT_BYTES = 24;                        // Payload length
    localparam logic [4:0] PKT_LAST_BEAT = 5'h17;        // Index of byte 23
    localparam logic [4:0] BYTE_CODE = 5'h00;            // Payload byte positions
    localparam logic [4:0] BYTE_OFFSET = 5'h01;
    localparam logic [4:0] BYTE_PRIO = 5'h02;
    localparam logic [4:0] BYTE_SRC = 5'h03;
    localparam logic [3:0] PRIO_FLOOR = 4'h0;            // Below any real priority

    // Per-source interrupt code, index 0 first (slot lines, OBIO, errors, gfx)
    localparam logic [CODE_W-1:0] SRC_CODE [SRC_COUNT] = '{
        6'h06, 6'h04, 6'h03, 6'h01, 6'h0e, 6'h0c, 6'h0b, 6'h09,
        6'h16, 6'h14, 6'h13, 6'h11, 6'h1e, 6'h1c, 6'h1b, 6'h19,
        6'h20, 6'h21, 6'h22, 6'h24, 6'h1f, 6'h25, 6'h28, 6'h29,
        6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h30, 6'h23};
    // Per-source mapping offset; graphics takes its offset elsewhere, sent as 0
    localparam logic [7:0] SRC_OFFSET [SRC_COUNT] = '{
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
        8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f,
        8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
        8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2e, 8'h2f, 8'h30, 8'h00};
    // Per-source priority, larger wins
    localparam logic [PRI_W-1:0] SRC_PRIO [SRC_COUNT] = '{
        4'h6, 4'h4, 4'h3, 4'h1, 4'h6, 4'h4, 4'h3, 4'h1,
        4'h6, 4'h4, 4'h3, 4'h1, 4'h6, 4'h4, 4'h3, 4'h1,
        4'h3, 4'h3, 4'h2, 4'h8, 4'h7, 4'h8, 4'h7, 4'h8,
        4'h2, 4'h4, 4'h4, 4'h7, 4'h8, 4'h8, 4'h8, 4'h5};
    localparam logic [IDX_W-1:0] GFX_IDX = 5'h1f;       // Pulse source slot

    // Concentrator result travelling down the register stages
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [IDX_W-1:0] idx;
    } iprt_conc_t;

    // Packet sender states
    typedef enum logic [0:0] {
        IPRT_IDLE = 1'b0,
        IPRT_SEND = 1'b1
    } iprt_state_t;
endpackage

//--- iprt_router.sv
// Interrupt concentrator and vector packet sender
`timescale 1ns/10ps
// Overview of operation
// - Interrupts reach processor only as packets
// - Each packet carries exactly 24 payload bytes
// - Level requests become packets, not wires
// - Slot lines map to codes, offsets 0x10-0x1F
// - Keyboard-named pin acts as second disk
module iprt_router (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Expansion slot lines, active low, slot-major INTA..INTD
    input wire logic [iprt_pkg::SLOT_LINES-1:0] SLOT_INT_N,
    // Onboard I/O level requests, active high
    input wire logic [iprt_pkg::OBIO_LINES-1:0] OBIO_INT,
    // Internal error requests, same clock, active high
    input wire logic [iprt_pkg::ERR_LINES-1:0] ERR_INT,
    // Graphics pulse request pin, active high
    input wire logic GFX_INT,
    // Vector packet write toward the processor module
    output logic PKT_VALID,
    output logic [7:0] PKT_DATA,
    output logic PKT_FIRST,
    output logic PKT_LAST,
    input wire logic PKT_READY,
    // Concentrator code after its register stage
    output logic [iprt_pkg::CODE_W-1:0] CONC_CODE
);
    import iprt_pkg::*;

    localparam int PIN_LINES = SLOT_LINES + OBIO_LINES + GFX_LINES;

    // Input conditioning
    logic [PIN_LINES-1:0] pin_raw;       // All pin-sourced requests, active high
    logic [PIN_LINES-1:0] sync1;         // First stage, read only by sync2
    logic [PIN_LINES-1:0] sync2;
    logic [PIN_LINES-1:0] sync3;
    logic [PIN_LINES-1:0] pin_filt;      // Accepted pin level
    logic gfx_prev;                      // Graphics level last cycle
    logic gfx_pend;                      // Captured graphics pulse
    // Arbitration and register stages
    logic [SRC_COUNT-1:0] level;         // Current request of every source
    logic [SRC_COUNT-1:0] sent;          // Level source already delivered
    logic [SRC_COUNT-1:0] eligible;      // Requests not yet delivered
    iprt_conc_t next_conc;               // Arbitration result
    iprt_conc_t conc_reg;                // Captured concentrator output
    iprt_conc_t conc_sync;               // Resynchronised code
    // Packet sender
    iprt_state_t state;                  // Idle or sending
    logic [IDX_W-1:0] cur_idx;           // Source being sent
    logic [4:0] beat;                    // Payload byte counter
    logic start;                         // Packet begins this cycle

    // Slot lines are active low; the graphics pin sits in the top bit
    assign pin_raw = {GFX_INT, OBIO_INT, ~SLOT_INT_N};

    // Three-stage input synchroniser
    // Pins are asynchronous to SYS_CLK; the first stage may go metastable
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Level only moves once two late stages agree, which rejects glitches
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pin_filt <= '0;
        end else begin
            for (int i = 0; i < PIN_LINES; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_filt[i] <= sync3[i];
                end
            end
        end
    end

    // Graphics is pulse type: a rising edge is held until its packet starts; one on a graphics launch edge is held for good, as sent[31] stays set
    // Limitation: a pulse arriving before the pending pulse's packet starts merges into one request
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            gfx_prev <= 1'b0;
            gfx_pend <= 1'b0;
        end else begin
            gfx_prev <= pin_filt[PIN_LINES-1];
            if (pin_filt[PIN_LINES-1] && !gfx_prev) begin
                gfx_pend <= 1'b1;                 // New pulse beats the clear
            end else if (start && conc_sync.idx == GFX_IDX) begin
                // Launch index, since cur_idx is only loaded on this edge
                gfx_pend <= 1'b0;
            end
        end
    end

    // Source vector; the keyboard-named pin is OBIO bit 6, the idle disk channel
    assign level = {gfx_pend, ERR_INT, pin_filt[PIN_LINES-2:0]};

    // Level sources are sent once, then wait for software to drop the request
    // Marked from the pipeline index on the launch edge; cur_idx there still
    // names the previous packet's source and would mark the wrong one
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sent <= '0;
        end else begin
            for (int i = 0; i < SRC_COUNT; i++) begin
                if (start && conc_sync.idx == IDX_W'(i)) begin
                    sent[i] <= 1'b1;
                end else if (!level[i]) begin
                    sent[i] <= 1'b0;
                end
            end
        end
    end

    assign eligible = level & ~sent;

    // Priority concentrator; ties go to the lowest source index
    // A plain scan is enough: 32 sources and one result per cycle
    always_comb begin
        logic [PRI_W-1:0] best;
        best = PRIO_FLOOR;
        next_conc.code = NO_INT_CODE;
        next_conc.idx = '0;
        for (int i = 0; i < SRC_COUNT; i++) begin
            if (eligible[i] && SRC_PRIO[i] > best) begin
                best = SRC_PRIO[i];
                next_conc.code = SRC_CODE[i];
                next_conc.idx = IDX_W'(i);
            end
        end
    end

    // Capture stage, then resync stage; costs two cycles of latency
    // CONC_CODE mirrors conc_reg so the far side sees the captured code
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            conc_reg <= '{code: NO_INT_CODE, idx: '0};
            conc_sync <= '{code: NO_INT_CODE, idx: '0};
            CONC_CODE <= NO_INT_CODE;
        end else begin
            conc_reg <= next_conc;
            CONC_CODE <= next_conc.code;
            conc_sync <= conc_reg;
        end
    end

    // The pipeline may still hold a source just sent; recheck it is eligible
    // A request that arrives while a packet is out waits in the pipeline
    assign start = (state == IPRT_IDLE) && (conc_sync.code != NO_INT_CODE)
                   && eligible[conc_sync.idx];

    // Payload byte for a beat: code, offset, priority, source, then zero
    function automatic logic [7:0] pkt_byte(input logic [4:0] b,
                                            input logic [IDX_W-1:0] s);
        logic [7:0] v;
        v = '0;
        case (b)
            BYTE_CODE: v = {2'h0, SRC_CODE[s]};
            BYTE_OFFSET: v = SRC_OFFSET[s];
            BYTE_PRIO: v = {4'h0, SRC_PRIO[s]};
            BYTE_SRC: v = {3'h0, s};
            default: v = '0;
        endcase
        return v;
    endfunction

    // Packet sender: every interrupt leaves only as one 24-byte write
    // Back-pressure only stalls the current byte; nothing is dropped or repeated
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state <= IPRT_IDLE;
            cur_idx <= '0;
            beat <= '0;
            PKT_VALID <= 1'b0;
            PKT_DATA <= '0;
            PKT_FIRST <= 1'b0;
            PKT_LAST <= 1'b0;
        end else begin
            case (state)
                IPRT_IDLE: begin
                    if (start) begin
                        state <= IPRT_SEND;
                        cur_idx <= conc_sync.idx;
                        beat <= '0;
                        PKT_VALID <= 1'b1;
                        PKT_FIRST <= 1'b1;
                        PKT_LAST <= 1'b0;
                        // Byte 0 is loaded together with the launch
                        PKT_DATA <= pkt_byte(BYTE_CODE, conc_sync.idx);
                    end
                end
                IPRT_SEND: begin
                    if (PKT_READY) begin
                        if (beat == PKT_LAST_BEAT) begin
                            // Valid drops; at least one idle cycle follows
                            state <= IPRT_IDLE;
                            PKT_VALID <= 1'b0;
                            PKT_LAST <= 1'b0;
                            PKT_DATA <= '0;
                        end else begin
                            beat <= beat + 5'h01;
                            PKT_FIRST <= 1'b0;
                            PKT_LAST <= (beat + 5'h01 == PKT_LAST_BEAT);
                            PKT_DATA <= pkt_byte(beat + 5'h01, cur_idx);
                        end
                    end
                end
                default: begin
                    state <= IPRT_IDLE;
                    PKT_VALID <= 1'b0;
                end
            endcase
        end
    end
endmodule // iprt_router

//--- iprt_rx_model.sv
// Receiver model for vector packets, with optional stalls
`timescale 1ns/10ps
module iprt_rx_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Byte stream from the router
    input wire logic valid,
    input wire logic [7:0] data,
    input wire logic first,
    input wire logic last,
    input wire logic slow,
    output logic ready
);
    logic [7:0] buf_q [24]; // Last packet bytes
    logic [15:0] lfsr; // Stall pattern
    int cnt; // Bytes in current packet
    int npkt; // Whole packets taken
    int bad_frame; // Taken bytes with wrong framing flags
    // Ready moves only after an edge; stalls come from the pattern
    always_ff @(posedge clk) begin
        lfsr <= rst_n ? {lfsr[14:0], lfsr[15] ^ lfsr[12]} : 16'h0001;
        ready <= rst_n && (!slow || lfsr[0]);
    end
    // Capture taken bytes; a packet counts at its last byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 0;
            npkt <= 0;
            bad_frame <= 0;
        end else if (valid && ready) begin
            buf_q[cnt] <= data;
            cnt <= (cnt == 23) ? 0 : cnt + 1;
            npkt <= npkt + int'(cnt == 23);
            bad_frame <= bad_frame + int'(first != (cnt == 0) || last != (cnt == 23));
        end
    end
endmodule // iprt_rx_model

//--- iprt_router_assertions.sv
// Port checker for the interrupt packet router
`timescale 1ns/10ps
module iprt_router_assertions (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Packet port and code
    input wire logic PKT_VALID,
    input wire logic [7:0] PKT_DATA,
    input wire logic PKT_FIRST,
    input wire logic PKT_LAST,
    input wire logic PKT_READY,
    input wire logic [iprt_pkg::CODE_W-1:0] CONC_CODE
);
    import iprt_pkg::*;
    logic [4:0] beat; // Bytes taken so far
    // Count taken bytes, back to zero after the last
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || (PKT_VALID && PKT_READY && PKT_LAST)) beat <= 5'h00;
        else if (PKT_VALID && PKT_READY) beat <= beat + 5'h01;
    end
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    chk_first_start: assert property ($rose(PKT_VALID) |-> PKT_FIRST && beat == 5'h00)
        else $error("bad start");
    chk_byte_hold: assert property (PKT_VALID && !PKT_READY |=> PKT_VALID && $stable(PKT_DATA))
        else $error("byte moved");
    chk_last_count: assert property (PKT_VALID |-> PKT_LAST == (beat == PKT_LAST_BEAT))
        else $error("bad length");
    chk_last_drop: assert property (PKT_VALID && PKT_READY && PKT_LAST |=> !PKT_VALID)
        else $error("no drop");
    chk_pad_zero: assert property (PKT_VALID && beat > 5'h03 |-> PKT_DATA == 8'h00)
        else $error("pad set");
    chk_idle_code: assert property (PKT_FIRST |-> PKT_DATA != {2'h0, NO_INT_CODE})
        else $error("idle sent");
    chk_code_match: assert property ($rose(PKT_VALID) |-> PKT_DATA == $past(CONC_CODE, 2))
        else $error("code lost");
endmodule // iprt_router_assertions
bind iprt_router iprt_router_assertions chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .PKT_VALID(PKT_VALID), .PKT_DATA(PKT_DATA), .PKT_FIRST(PKT_FIRST),
    .PKT_LAST(PKT_LAST), .PKT_READY(PKT_READY), .CONC_CODE(CONC_CODE));

//--- testbench.sv
// Self-checking bench for the interrupt packet router
`timescale 1ns/10ps
module testbench;
    import iprt_pkg::*;
    logic SYS_CLK = 1'b0; // 10 MHz clock
    logic RST_N = 1'b0; // Reset, low active
    logic [SLOT_LINES-1:0] SLOT_INT_N = '1;
    logic [OBIO_LINES-1:0] OBIO_INT = '0;
    logic [ERR_LINES-1:0] ERR_INT = '0;
    logic GFX_INT = 1'b0;
    logic PKT_VALID, PKT_FIRST, PKT_LAST, PKT_READY;
    logic [7:0] PKT_DATA;
    logic [CODE_W-1:0] CONC_CODE;
    logic slow = 1'b0; // Receiver stall mode
    logic [31:0] rng = 32'h00011b63; // Xorshift state, seed 72547
    int error_cnt = 0;
    int comparisons = 0;
    always #50 SYS_CLK = ~SYS_CLK;
    iprt_router dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SLOT_INT_N(SLOT_INT_N),
        .OBIO_INT(OBIO_INT), .ERR_INT(ERR_INT), .GFX_INT(GFX_INT), .PKT_VALID(PKT_VALID),
        .PKT_DATA(PKT_DATA), .PKT_FIRST(PKT_FIRST), .PKT_LAST(PKT_LAST),
        .PKT_READY(PKT_READY), .CONC_CODE(CONC_CODE));
    iprt_rx_model rx (.clk(SYS_CLK), .rst_n(RST_N), .valid(PKT_VALID), .data(PKT_DATA),
        .first(PKT_FIRST), .last(PKT_LAST), .slow(slow), .ready(PKT_READY));
    // Xorshift step
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // Slot lines follow the INTA..INTD pattern
    function automatic int prio(int i);
        int sp [4] = '{6, 4, 3, 1};
        if (i < 16) return sp[i % 4];
        return (i == 22) ? 7 : int'(SRC_PRIO[i]);
    endfunction
    // Expected payload byte b of source i
    function automatic logic [7:0] exp_byte(int i, int b);
        case (b)
            0: return (i < 16) ? 8'(8 * (i / 4) + prio(i)) : (i == 22) ? 8'h28 : 8'(SRC_CODE[i]);
            1: return (i < 16) ? 8'(8'h10 + i) : (i == 22) ? 8'h26 : SRC_OFFSET[i];
            2: return 8'(prio(i));
            3: return 8'(i);
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Raise or drop source i on its own pin
    task automatic drive(int i, logic v);
        if (i < 16) SLOT_INT_N[i] = ~v;
        else if (i < 28) OBIO_INT[i - 16] = v;
        else if (i < 31) ERR_INT[i - 28] = v;
        else GFX_INT = v;
    endtask
    // Wait, bounded, for one packet and compare it whole
    task automatic get_pkt(int i);
        int n;
        n = rx.npkt;
        for (int t = 0; t < 300 && rx.npkt == n; t++) @(negedge SYS_CLK);
        check("packet count", 8'(rx.npkt - n), 8'h01);
        for (int b = 0; b < PKT_BYTES; b++) check("payload", rx.buf_q[b], exp_byte(i, b));
        check("framing", 8'(rx.bad_frame), 8'h00);
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        int a, b, w, n;
        repeat (3) @(negedge SYS_CLK);
        RST_N = 1'b1;
        check("idle code", 8'(CONC_CODE), 8'(NO_INT_CODE));
        // Each source alone; held levels must not repeat
        for (int i = 0; i < SRC_COUNT; i++) begin
            slow = 1'(xs() >> 3);
            drive(i, 1'b1);
            if (i == 31) begin
                repeat (2) @(negedge SYS_CLK);
                drive(i, 1'b0);
            end
            get_pkt(i);
            n = rx.npkt;
            repeat (20) @(negedge SYS_CLK);
            check("no resend", 8'(rx.npkt - n), 8'h00);
            check("held code", 8'(CONC_CODE), 8'(NO_INT_CODE));
            drive(i, 1'b0);
            repeat (8) @(negedge SYS_CLK);
        end
        // Random pairs of synchronised pins: winner first, then the other
        for (int k = 0; k < 8; k++) begin
            a = int'(xs() % 28);
            b = int'((a + 1 + xs() % 27) % 28);
            w = (prio(a) > prio(b) || (prio(a) == prio(b) && a < b)) ? a : b;
            drive(a, 1'b1);
            drive(b, 1'b1);
            get_pkt(w);
            get_pkt(a + b - w);
            drive(a, 1'b0);
            drive(b, 1'b0);
            repeat (8) @(negedge SYS_CLK);
        end
        stop_test();
    end
    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        error_cnt++;
        stop_test();
    end
endmodule // testbench
